// File: rtl/scr_i2c_slave.sv
// i2c-compatible slave engine: start/stop detect, address match, byte transfers
// assumes scl/sda already synchronous to clk_i; sda open-drain as three signals
`timescale 1ns/1ps
`include "scr_map.svh"
module scr_i2c_slave (
  input  wire logic            clk_i,
  input  wire logic            rstn_i,
  input  wire logic            enable_i,
  input  wire logic [6:0]      dev_addr_i,
  input  wire logic            scl_i,
  input  wire logic            sda_i,
  output logic                 sda_o,
  output logic                 sda_oe_o,
  output scr_pkg::scr_req_t    req_o,
  output logic                 req_vld_o,
  input  wire logic [7:0]      rdata_i
);
  import scr_pkg::*;
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ACK, ST_RX, ST_TX, ST_RACK} scr_st_t;
  scr_st_t     st_r;
  logic        scl_q_r;
  logic        sda_q_r;
  logic [7:0]  sh_r;
  logic [3:0]  cnt_r;
  logic        rd_r;
  logic        have_ptr_r;
  logic [7:0]  ptr_r;
  logic        drv_r;
  logic        vld_r;
  scr_req_t    req_r;
  wire         scl_rise = scl_i & ~scl_q_r;
  wire         scl_fall = ~scl_i & scl_q_r;
  wire         start_c  = scl_i & scl_q_r & sda_q_r & ~sda_i;
  wire         stop_c   = scl_i & scl_q_r & ~sda_q_r & sda_i;
  wire [7:0]   sh_nxt   = {sh_r[6:0], sda_i};
  // reads look up the live pointer; a write shows the offset it latched
  wire [7:0]   look_addr = vld_r ? req_r.addr : ptr_r;
  assign sda_o     = 1'b0;
  assign sda_oe_o  = drv_r;
  assign req_o     = '{wr: req_r.wr, addr: look_addr, wdata: req_r.wdata};
  assign req_vld_o = vld_r;
  always_ff @(posedge clk_i) begin
    scl_q_r <= scl_i;
    sda_q_r <= sda_i;
    vld_r   <= 1'b0;
    if (!rstn_i || !enable_i || stop_c) begin
      st_r <= ST_IDLE;
      drv_r <= 1'b0;
      cnt_r <= 4'h0;
      if (!rstn_i) begin
        have_ptr_r <= 1'b0;
        ptr_r <= 8'h00;
        rd_r <= 1'b0;
        sh_r <= 8'h00;
        req_r <= '0;
      end
      have_ptr_r <= 1'b0;
    end else if (start_c) begin
      st_r <= ST_ADDR;
      cnt_r <= 4'h0;
      drv_r <= 1'b0;
      have_ptr_r <= 1'b0;
    end else begin
      case (st_r)
        ST_ADDR, ST_RX: begin
          if (scl_rise) begin
            sh_r <= sh_nxt;
            cnt_r <= cnt_r + 4'h1;
          end
          if (scl_fall && cnt_r == 4'h8) begin
            cnt_r <= 4'h0;
            if (st_r == ST_ADDR) begin
              if (sh_r[7:1] == dev_addr_i) begin
                rd_r <= sh_r[0];
                drv_r <= 1'b1;
                st_r <= ST_ACK;
              end else begin
                st_r <= ST_IDLE;
              end
            end else begin
              drv_r <= 1'b1;
              st_r <= ST_ACK;
              if (!have_ptr_r) begin
                ptr_r <= sh_r;
                have_ptr_r <= 1'b1;
              end else begin
                req_r <= '{wr: 1'b1, addr: ptr_r, wdata: sh_r};
                vld_r <= 1'b1;
                ptr_r <= ptr_r + 8'h01;
              end
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            if (rd_r) begin
              sh_r <= rdata_i;
              drv_r <= ~rdata_i[7];
              cnt_r <= 4'h1;
              ptr_r <= ptr_r + 8'h01;
              st_r <= ST_TX;
            end else begin
              drv_r <= 1'b0;
              st_r <= ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (cnt_r == 4'h8) begin
              drv_r <= 1'b0;
              st_r <= ST_RACK;
            end else begin
              sh_r <= {sh_r[6:0], 1'b0};
              drv_r <= ~sh_r[6];
              cnt_r <= cnt_r + 4'h1;
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            st_r <= sda_i ? ST_IDLE : ST_ACK;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end
endmodule

// File: rtl/scr_map.svh
// register offsets, field positions, reset values and timing for the config bank
// assumes inclusion by rtl files; no logic inside
`ifndef SCR_MAP_SVH
`define SCR_MAP_SVH
`define SCR_OFF_LINK_CONFIG     8'h00
`define SCR_OFF_BUS_ADDRESS     8'h01
`define SCR_OFF_EMPHASIS        8'h02
`define SCR_LC_REG_CONTROL      0
`define SCR_LC_MODE_LO          2
`define SCR_LC_MODE_HI          3
`define SCR_LC_LATCH_EDGE       4
`define SCR_LC_SWING            5
`define SCR_BA_SOURCE           7
`define SCR_EM_DISABLE          4
`define SCR_EM_LEVEL_LO         5
`define SCR_EM_LEVEL_HI         7
`define SCR_RST_LINK_CONFIG     8'h00
`define SCR_RST_BUS_ADDRESS     8'h68
`define SCR_RST_EMPHASIS        8'h00
`define SCR_CLK_MHZ             200
`define SCR_STARTUP_MS          10
`define SCR_STARTUP_CYC         (`SCR_STARTUP_MS * 1000 * `SCR_CLK_MHZ)
`endif

// File: rtl/scr_pkg.sv
// types shared by the config bank and its bus engine
// assumes it is compiled before every file that imports it
package scr_pkg;
  typedef enum logic [1:0] {
    SCR_MODE_NORM_NOFILT,
    SCR_MODE_NORM_FILT,
    SCR_MODE_LEGACY_GEN2,
    SCR_MODE_LEGACY_GEN1
  } scr_mode_t;
  typedef struct packed {
    logic       filter_en;
    logic       legacy_gen2;
    logic       legacy_gen1;
    logic       latch_rising;
    logic       swing_high;
    logic [2:0] emph_level;
    logic       emph_en;
  } scr_cfg_t;
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } scr_req_t;
endpackage

// File: rtl/scr_config_bank.sv
// serializer configuration bank reached over the serial control bus
// assumes pins synchronous to clk_i, reset held at power-up
//
// Operation
// - bit0 of link_config: 0 uses strap pins, 1 uses registers except address
// - bus_address_setting bit7 picks strap address or register address
// - address field bits 6:0, read/write, resets to 1101000
// - link_config bits 3:2 select mode, reset 00
// - link_config bit4: 0 latches on falling edge, 1 on rising
// - emphasis bits 7:5: 000 external resistor, others fixed levels
// - emphasis bit4 low enables de-emphasis, high disables
// - no bus response for 10 ms after power-up
// - device acks every written byte; host acks reads, ends nack and stop
`timescale 1ns/1ps
`include "scr_map.svh"
module scr_config_bank #(
  parameter int unsigned STARTUP_CYC = `SCR_STARTUP_CYC
) (
  input  wire logic             clk_i,
  input  wire logic             rstn_i,
  input  wire logic             scl_i,
  input  wire logic             sda_i,
  output logic                  sda_o,
  output logic                  sda_oe_o,
  input  wire logic [6:0]       strap_addr_i,
  input  wire logic [1:0]       strap_mode_i,
  input  wire logic             strap_latch_rising_i,
  input  wire logic             strap_swing_high_i,
  output scr_pkg::scr_cfg_t     cfg_o,
  output logic                  bus_ready_o
);
  import scr_pkg::*;
  if (STARTUP_CYC < 1) begin : g_bad_startup
    $error("STARTUP_CYC must be at least 1");
  end
  logic [7:0]  link_config_r;
  logic [7:0]  bus_address_setting_r;
  logic [7:0]  emphasis_control_r;
  logic [31:0] wait_r;
  logic        ready_r;
  scr_cfg_t    cfg_r;
  scr_cfg_t    cfg_nxt;
  scr_req_t    req;
  logic        req_vld;
  logic [7:0]  rdata;
  wire         reg_ctl     = link_config_r[`SCR_LC_REG_CONTROL];
  wire [1:0]   mode_sel    = reg_ctl ? link_config_r[`SCR_LC_MODE_HI:`SCR_LC_MODE_LO]
                                     : strap_mode_i;
  wire         latch_sel   = reg_ctl ? link_config_r[`SCR_LC_LATCH_EDGE]
                                     : strap_latch_rising_i;
  wire         swing_sel   = reg_ctl ? link_config_r[`SCR_LC_SWING]
                                     : strap_swing_high_i;
  wire [2:0]   emph_lvl    = reg_ctl ? emphasis_control_r[`SCR_EM_LEVEL_HI:`SCR_EM_LEVEL_LO]
                                     : 3'h0;
  wire         emph_dis    = reg_ctl & emphasis_control_r[`SCR_EM_DISABLE];
  // address selection ignores reg_ctl on purpose
  wire [6:0]   dev_addr    = bus_address_setting_r[`SCR_BA_SOURCE]
                             ? bus_address_setting_r[6:0] : strap_addr_i;
  wire         wr_link     = req_vld && req.wr && req.addr == `SCR_OFF_LINK_CONFIG;
  wire         wr_addr     = req_vld && req.wr && req.addr == `SCR_OFF_BUS_ADDRESS;
  wire         wr_emph     = req_vld && req.wr && req.addr == `SCR_OFF_EMPHASIS;
  assign rdata = (req.addr == `SCR_OFF_LINK_CONFIG) ? link_config_r
               : (req.addr == `SCR_OFF_BUS_ADDRESS) ? bus_address_setting_r
               : (req.addr == `SCR_OFF_EMPHASIS)    ? emphasis_control_r
               : 8'h00;
  always_comb begin
    cfg_nxt              = '0;
    cfg_nxt.filter_en    = (mode_sel == SCR_MODE_NORM_FILT);
    cfg_nxt.legacy_gen2  = (mode_sel == SCR_MODE_LEGACY_GEN2);
    cfg_nxt.legacy_gen1  = (mode_sel == SCR_MODE_LEGACY_GEN1);
    cfg_nxt.latch_rising = latch_sel;
    cfg_nxt.swing_high   = swing_sel;
    cfg_nxt.emph_level   = emph_lvl;
    cfg_nxt.emph_en      = ~emph_dis;
  end
  assign cfg_o       = cfg_r;
  assign bus_ready_o = ready_r;
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      wait_r  <= 32'h0;
      ready_r <= 1'b0;
    end else if (!ready_r) begin
      wait_r  <= wait_r + 32'h1;
      ready_r <= (wait_r >= 32'(STARTUP_CYC - 1));
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      link_config_r         <= `SCR_RST_LINK_CONFIG;
      bus_address_setting_r <= `SCR_RST_BUS_ADDRESS;
      emphasis_control_r    <= `SCR_RST_EMPHASIS;
      cfg_r                 <= '0;
    end else begin
      cfg_r <= cfg_nxt;
      if (wr_link) link_config_r <= req.wdata;
      if (wr_addr) bus_address_setting_r <= req.wdata;
      if (wr_emph) emphasis_control_r <= req.wdata;
    end
  end
  scr_i2c_slave u_bus (
    .clk_i      (clk_i),
    .rstn_i     (rstn_i),
    .enable_i   (ready_r),
    .dev_addr_i (dev_addr),
    .scl_i      (scl_i),
    .sda_i      (sda_i),
    .sda_o      (sda_o),
    .sda_oe_o   (sda_oe_o),
    .req_o      (req),
    .req_vld_o  (req_vld),
    .rdata_i    (rdata)
  );
endmodule

// File: bench/scr_config_bank_properties.sv
// port checker for the config bank: startup wait, sda timing, strap path
// assumes a bind to scr_config_bank with its STARTUP_CYC handed on
`timescale 1ns/1ps
module scr_config_bank_properties #(parameter int unsigned STARTUP_CYC = 20) (
  input wire logic              clk_i,
  input wire logic              rstn_i,
  input wire logic              scl_i,
  input wire logic              sda_o,
  input wire logic              sda_oe_o,
  input wire logic [1:0]        strap_mode_i,
  input wire logic              strap_latch_rising_i,
  input wire logic              strap_swing_high_i,
  input wire scr_pkg::scr_cfg_t cfg_o,
  input wire logic              bus_ready_o
);
  import scr_pkg::*;
  logic [31:0] up_r;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  always_ff @(posedge clk_i)
    if (!rstn_i) up_r <= 32'h0;
    else if (up_r < STARTUP_CYC + 4) up_r <= up_r + 32'h1;
  chk_wait_early: assert property (up_r < STARTUP_CYC |-> !bus_ready_o)
    else $error("bus ready too early");
  chk_wait_done: assert property (up_r >= STARTUP_CYC |-> bus_ready_o)
    else $error("bus ready too late");
  chk_quiet_start: assert property (!bus_ready_o |-> !sda_oe_o)
    else $error("sda driven before ready");
  chk_open_drain: assert property (sda_oe_o |-> !sda_o)
    else $error("sda driven high");
  chk_scl_high_hold: assert property (scl_i |=> $stable(sda_oe_o))
    else $error("sda moved while scl high");
  chk_strap_mode: assert property ($past(rstn_i) && !bus_ready_o |->
    cfg_o.filter_en == ($past(strap_mode_i) == 2'h1) &&
    cfg_o.legacy_gen2 == ($past(strap_mode_i) == 2'h2) &&
    cfg_o.legacy_gen1 == ($past(strap_mode_i) == 2'h3)) else $error("strap mode lost");
  chk_strap_edge: assert property ($past(rstn_i) && !bus_ready_o |->
    cfg_o.latch_rising == $past(strap_latch_rising_i) &&
    cfg_o.swing_high == $past(strap_swing_high_i)) else $error("strap edge lost");
  chk_strap_emph: assert property ($past(rstn_i) && !bus_ready_o |->
    cfg_o.emph_level == 3'h0 && cfg_o.emph_en) else $error("strap emphasis wrong");
endmodule
bind scr_config_bank scr_config_bank_properties #(.STARTUP_CYC(STARTUP_CYC)) u_props (
  .clk_i, .rstn_i, .scl_i, .sda_o, .sda_oe_o, .strap_mode_i, .strap_latch_rising_i,
  .strap_swing_high_i, .cfg_o, .bus_ready_o);

// File: bench/scr_host_model.sv
// bus host model: start, stop and byte transfers on the control bus
// assumes a pull-up on sda; sda_low_o high pulls the wire low
`timescale 1ns/1ps
module scr_host_model (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o = 1'h1,
  output logic      sda_low_o = 1'h0
);
  // set both lines, then hold them for a third of a bit
  task automatic sp(input logic c, input logic d);
    scl_o = c;
    sda_low_o = d;
    repeat (4) @(negedge clk_i);
  endtask
  task automatic bt(input logic b, output logic s);
    sp(1'h0, ~b);
    sp(1'h1, ~b);
    s = sda_i;
    sp(1'h0, ~b);
  endtask
  task automatic start();
    sp(scl_o, 1'h0);
    sp(1'h1, 1'h0);
    sp(1'h1, 1'h1);
    sp(1'h0, 1'h1);
  endtask
  task automatic stop();
    sp(1'h0, 1'h1);
    sp(1'h1, 1'h1);
    sp(1'h1, 1'h0);
  endtask
  task automatic wb(input logic [7:0] d, output logic k);
    logic s;
    for (int i = 7; i >= 0; i--)
      bt(d[i], s);
    bt(1'h1, s);
    k = ~s;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] p, v, output logic ack);
    logic k1, k2, k3;
    start();
    wb({a, 1'h0}, k1);
    wb(p, k2);
    wb(v, k3);
    stop();
    ack = k1 & k2 & k3;
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] p, input int n,
                    output logic [23:0] q, output logic ack);
    logic k1, k2, k3, s;
    logic [7:0] b;
    q = 24'h0;
    start();
    wb({a, 1'h0}, k1);
    wb(p, k2);
    start();
    wb({a, 1'h1}, k3);
    for (int i = 0; i < n; i++) begin
      for (int j = 7; j >= 0; j--)
        bt(1'h1, b[j]);
      bt(i == n - 1, s);
      q = {q[15:0], b};
    end
    stop();
    ack = k1 & k2 & k3;
  endtask
endmodule

// File: bench/scr_config_bank_tb.sv
// self-checking bench for the config bank, driven through the bus host model
// assumes a shortened startup wait; strap pins are driven from the bench
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    n_checks++; \
    if ((g) !== (e)) begin \
      n_mismatch++; \
      $display("[ERR] %s exp %h got %h", nm, e, g); \
    end \
  end
module scr_config_bank_tb;
  import scr_pkg::*;
  logic        clk_i = 1'h0;
  logic        rstn_i = 1'h0;
  logic        scl, sda_low, sda_o, sda_oe, ready, ack;
  logic [23:0] q;
  scr_cfg_t    cfg;
  logic [1:0]  st_mode = 2'h1;
  logic        st_edge = 1'h1;
  logic        st_swing = 1'h1;
  int          n_mismatch = 0;
  int          n_checks = 0;
  wire         sda_w = ~(sda_low | (sda_oe & ~sda_o));
  always #2.5 clk_i = ~clk_i;
  scr_host_model host (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl), .sda_low_o(sda_low));
  scr_config_bank #(.STARTUP_CYC(400)) dut (.clk_i(clk_i), .rstn_i(rstn_i), .scl_i(scl),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe), .strap_addr_i(7'h6B),
    .strap_mode_i(st_mode), .strap_latch_rising_i(st_edge), .strap_swing_high_i(st_swing),
    .cfg_o(cfg), .bus_ready_o(ready));
  function automatic scr_cfg_t ec(input logic [1:0] m, input logic l, s,
                                  input logic [2:0] v, input logic e);
    ec = {m == 2'h1, m == 2'h2, m == 2'h3, l, s, v, e};
  endfunction
  task automatic w(input logic [6:0] a, input logic [7:0] p, v);
    host.wr(a, p, v, ack);
    `CHK("write ack", 1'h1, ack)
  endtask
  task automatic r(input logic [6:0] a, input logic [7:0] p, input int n);
    host.rd(a, p, n, q, ack);
    `CHK("read ack", 1'h1, ack)
  endtask
  task automatic close_out();
    if (n_mismatch == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge clk_i);
    rstn_i = 1'h1;
    host.wr(7'h6B, 8'h00, 8'h01, ack);
    `CHK("early ack", 1'h0, ack)
    for (int i = 0; i < 1000 && ready !== 1'h1; i++)
      @(negedge clk_i);
    `CHK("ready", 1'h1, ready)
    `CHK("strap cfg", ec(2'h1, 1'h1, 1'h1, 3'h0, 1'h1), cfg)
    r(7'h6B, 8'h00, 3);
    `CHK("reset regs", 24'h006800, q)
    host.wr(7'h69, 8'h00, 8'h01, ack);
    `CHK("foreign addr", 1'h0, ack)
    for (int m = 0; m < 4; m++) begin
      w(7'h6B, 8'h00, {2'h3, m[1], m[0], m[1:0], 2'h1});
      `CHK("mode cfg", ec(m[1:0], m[0], m[1], 3'h0, 1'h1), cfg)
      r(7'h6B, 8'h00, 1);
      `CHK("config back", {2'h3, m[1], m[0], m[1:0], 2'h1}, q[7:0])
    end
    for (int lv = 0; lv < 8; lv++) begin
      w(7'h6B, 8'h02, {lv[2:0], lv[0], 4'h5});
      `CHK("emphasis cfg", ec(2'h3, 1'h1, 1'h1, lv[2:0], ~lv[0]), cfg)
    end
    r(7'h6B, 8'h02, 1);
    `CHK("emphasis back", 8'hF5, q[7:0])
    w(7'h6B, 8'h01, 8'hEE);
    host.wr(7'h6B, 8'h00, 8'h00, ack);
    `CHK("old addr", 1'h0, ack)
    r(7'h6E, 8'h01, 1);
    `CHK("address back", 8'hEE, q[7:0])
    w(7'h6E, 8'h00, 8'h00);
    `CHK("strap again", ec(2'h1, 1'h1, 1'h1, 3'h0, 1'h1), cfg)
    st_mode = 2'h2;
    st_edge = 1'h0;
    st_swing = 1'h0;
    repeat (2) @(negedge clk_i);
    `CHK("strap follow", ec(2'h2, 1'h0, 1'h0, 3'h0, 1'h1), cfg)
    r(7'h6E, 8'h05, 1);
    `CHK("unmapped read", 8'h00, q[7:0])
    // reset in mid-run: defaults back, startup wait starts over
    rstn_i = 1'h0;
    repeat (6) @(negedge clk_i);
    rstn_i = 1'h1;
    `CHK("ready after reset", 1'h0, ready)
    for (int i = 0; i < 1000 && ready !== 1'h1; i++)
      @(negedge clk_i);
    `CHK("ready again", 1'h1, ready)
    `CHK("strap after reset", ec(2'h2, 1'h0, 1'h0, 3'h0, 1'h1), cfg)
    r(7'h6B, 8'h00, 3);
    `CHK("regs after reset", 24'h006800, q)
    close_out();
  end
  initial begin
    repeat (40000) @(posedge clk_i);
    n_mismatch++;
    close_out();
  end
endmodule
